// *** src/cwr_pkg.sv ***
// Constants shared by the watchdog, reset and interrupt controller
package cwr_pkg;
    // Register map
    localparam logic [7:0]  MISC_OFS     = 8'h0c;
    localparam logic [7:0]  STAT_OFS     = 8'h0d;
    // Miscellaneous register fields
    localparam int          POR_B        = 7;
    localparam int          EXT_IRQ_ENABLE_BIT_B       = 4;
    localparam int          SM_B         = 1;
    localparam int          WATCHDOG_ARM_BIT_B       = 0;
    // Status register fields
    localparam int          ST_CNT_LSB   = 0;
    localparam int          ST_WAIT_B    = 3;
    localparam int          ST_STOP_B    = 4;
    localparam int          ST_IBIT_B    = 5;
    // Vectors, highest priority first
    localparam logic [15:0] VEC_RESET    = 16'h1ffe;
    localparam logic [15:0] VEC_SWI      = 16'h1ffc;
    localparam logic [15:0] VEC_IRQ      = 16'h1ffa;
    localparam logic [15:0] VEC_CAP      = 16'h1ff8;
    localparam logic [15:0] VEC_CMP      = 16'h1ff6;
    localparam logic [15:0] VEC_OVF      = 16'h1ff4;
    localparam logic [15:0] VEC_SCI      = 16'h1ff2;
    // Reset load values
    localparam logic [15:0] TMR_INIT     = 16'hfffc;
    localparam logic [15:0] SP_INIT      = 16'h00ff;
    // Watchdog chain
    localparam int          PRE4_W       = 2;
    localparam int          PRE256_W     = 8;
    localparam int          PRE_W        = PRE4_W + PRE256_W;
    localparam int          DOG_W        = 3;
    localparam logic [2:0]  DOG_FINAL    = 3'h7;
    // Timing
    localparam int          CLK_NS       = 20;
    localparam int          OSC_HOLD_CYC = 4064;
    localparam int          DOGL_NS      = 1000;
    localparam int          DOGL_CYC     = (DOGL_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CNT_W        = 12;

    typedef enum logic [5:0] {
        S_PWR  = 6'b000001,
        S_DOG  = 6'b000010,
        S_HOLD = 6'b000100,
        S_RUN  = 6'b001000,
        S_STOP = 6'b010000,
        S_STUP = 6'b100000
    } cwr_state_type;
endpackage

// *** src/cwr_ctrl.sv ***
// Watchdog, reset-effect sequencer and interrupt arbiter
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps

// What this block does
// - Watchdog: div4, div256, then resettable div8
// - Chain clocked by timer bit-7 carry
// - Enabled by option or software writing one
// - Writing zero never stops the watchdog
// - Writing one clears the div8 counter
// - Watchdog reset restores option-defined enable bit
// - Counter final state raises chip reset
// - Drive pin, release after minimum low time
// - STOP with watchdog on becomes watchdog reset
// - WAIT option: keep counting or hold off
// - Reset inits timer, directions, stack pointer
// - Reset sets irq enable, clears latches; power-on alone sets power flag
// - Reset disables serial, sets transmit flags
// - Power-on and STOP hold oscillator 4064 cycles
// - Reset or STOP clears converter, slow, memory
// - WAIT/STOP clear mask; resets set it
// - Any reset aborts and fetches reset vector
// - Interrupt pushes and masks; return restores mask
// - Service at instruction end if unmasked, enabled
// - Fixed priority with own vector pairs
// - Software trap ignores mask, own vector
// - Power flag cleared by zero, never set
module cwr_ctrl
    import cwr_pkg::*;
#(
    parameter logic WATCHDOG_ARM_BIT_OPT = 1'b0,
    parameter logic WAIT_RUN = 1'b1,
    parameter int   PORL_CYC = OSC_HOLD_CYC
) (
    input  wire logic        REF_CLK,      // Bus clock
    input  wire logic        RST_N,        // Power-on reset
    input  wire logic [7:0]  ADDR,         // Register address
    input  wire logic [7:0]  WDATA,        // Write data
    input  wire logic        WR,           // Write strobe
    input  wire logic        RD,           // Read strobe
    output logic      [7:0]  RDATA,        // Read data
    input  wire logic        RESET_PIN_I,  // Reset pin level
    output logic             RESET_PIN_O,  // Reset pin drive value
    output logic             RESET_PIN_OE, // Reset pin pulled low
    input  wire logic        TMR_CARRY,    // Timer bit-7 carry pulse
    input  wire logic        INSTR_DONE,   // Instruction completed
    input  wire logic        SWI_EXEC,     // Software trap executes
    input  wire logic        RTI_EXEC,     // Return from trap
    input  wire logic        STACKED_I,    // Mask bit from stack
    input  wire logic        STOP_EXEC,    // STOP instruction
    input  wire logic        WAIT_EXEC,    // WAIT instruction
    input  wire logic        IRQ_EVT,      // External irq sensed
    input  wire logic [3:0]  HW_REQ,       // Capture,compare,ovf,sci
    input  wire logic [3:0]  HW_EN,        // Their enables
    output logic             CHIP_RST,     // Abort, peripheral reset
    output logic             FETCH_RV,     // Reset vector fetch pulse
    output logic             INT_TAKE,     // Push registers pulse
    output logic      [15:0] VEC_ADDR,     // Vector being fetched
    output logic             I_BIT,        // Interrupt mask bit
    output logic             OSC_EN,       // Oscillator running
    output logic             CLK_CLR,      // Timer, serial clocks clear
    output logic             ADC_EEP_RST,  // Converter, memory reset
    output logic             SM_BIT,       // Slow mode bit
    output logic             EXT_IRQ_ENABLE_BIT_BIT,     // External irq enable
    output logic      [15:0] TMR_LOAD,     // Timer reset value
    output logic      [15:0] SP_LOAD,      // Stack pointer reset
    output logic             IN_WAIT,      // Wait latch
    output logic             IN_STOP       // Stop latch
);

    logic                rs1_r, rst_n_r;
    logic                ps1_r, pin_r;
    cwr_state_type       st_r, st_nxt;
    logic [CNT_W-1:0]    cnt_r;
    logic [PRE_W-1:0]    pre_r;
    logic [DOG_W-1:0]    dog_r;
    logic                watchdog_arm_bit_r, por_r, ext_irq_enable_bit_r, sm_r;
    logic                ibit_r, wait_r, stop_r, irq_r;
    logic                take_r, fetch_r;
    logic [15:0]         vec_r;
    logic [7:0]          rdata_r;
    logic                in_rst, wr_misc, dog_hold, dog_tick;
    logic                dog_clr, timeout, hw_any;
    logic [4:0]          req;

    // Highest set request wins: irq, capture, compare, ovf, serial
    function automatic logic [15:0] pick_vec(input logic [4:0] r);
        if (r[4])      pick_vec = VEC_IRQ;
        else if (r[3]) pick_vec = VEC_CAP;
        else if (r[2]) pick_vec = VEC_CMP;
        else if (r[1]) pick_vec = VEC_OVF;
        else           pick_vec = VEC_SCI;
    endfunction

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rs1_r   <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rs1_r   <= 1'b1;
            rst_n_r <= rs1_r;
        end
    end

    // Pin is asynchronous to the bus clock
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ps1_r <= 1'b1;
            pin_r <= 1'b1;
        end else begin
            ps1_r <= RESET_PIN_I;
            pin_r <= ps1_r;
        end
    end

    assign in_rst  = (st_r == S_PWR) || (st_r == S_DOG) || (st_r == S_HOLD);
    assign wr_misc = WR && (ADDR == MISC_OFS);
    assign timeout = watchdog_arm_bit_r && (dog_r == DOG_FINAL);
    assign req     = {irq_r && ext_irq_enable_bit_r, HW_REQ & HW_EN};
    assign hw_any  = |req;

    // Sequencer
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            S_PWR:  if (cnt_r >= CNT_W'(PORL_CYC - 1)) st_nxt = S_HOLD;
            S_DOG:  if (!pin_r && cnt_r >= CNT_W'(DOGL_CYC - 1))
                        st_nxt = S_HOLD;
            S_HOLD: if (pin_r) st_nxt = S_RUN;
            S_RUN: begin
                if (!pin_r) st_nxt = S_HOLD;
                else if (timeout) st_nxt = S_DOG;
                else if (STOP_EXEC && watchdog_arm_bit_r) st_nxt = S_DOG;
                else if (STOP_EXEC) st_nxt = S_STOP;
            end
            S_STOP: begin
                if (!pin_r) st_nxt = S_HOLD;
                else if (IRQ_EVT) st_nxt = S_STUP;
            end
            S_STUP: if (cnt_r >= CNT_W'(OSC_HOLD_CYC - 1))
                        st_nxt = S_RUN;
            default: st_nxt = S_PWR;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) st_r <= S_PWR;
        else          st_r <= st_nxt;
    end

    // Cycle counter for delays; in S_DOG it counts low pin cycles only
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_r <= '0;
        end else if (st_nxt != st_r) begin
            cnt_r <= '0;
        end else if (st_r == S_DOG) begin
            cnt_r <= pin_r ? '0 : cnt_r + 1'b1;
        end else if (st_r == S_PWR || st_r == S_STUP) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Watchdog chain: the first two stages clear only in reset; div8 also clears on a kick, held WAIT or STOP
    assign dog_hold = wait_r && !WAIT_RUN;
    assign dog_tick = TMR_CARRY && (&pre_r);
    assign dog_clr  = in_rst || dog_hold || st_r == S_STOP
                   || (wr_misc && WDATA[WATCHDOG_ARM_BIT_B]);

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r)    pre_r <= '0;
        else if (in_rst) pre_r <= '0;
        else if (TMR_CARRY) pre_r <= pre_r + 1'b1;
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r)
            dog_r <= '0;
        else if (dog_clr)
            dog_r <= '0;
        else if (watchdog_arm_bit_r && dog_tick && dog_r != DOG_FINAL)
            dog_r <= dog_r + 1'b1;
    end

    // Any reset or STOP brings the enable back to the build option
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r)
            watchdog_arm_bit_r <= WATCHDOG_ARM_BIT_OPT;
        else if (in_rst || st_r == S_STOP)
            watchdog_arm_bit_r <= WATCHDOG_ARM_BIT_OPT;
        else if (wr_misc && WDATA[WATCHDOG_ARM_BIT_B])
            watchdog_arm_bit_r <= 1'b1;
    end

    // Power flag survives every reset except power-on
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r)
            por_r <= 1'b1;
        else if (wr_misc && !WDATA[POR_B])
            por_r <= 1'b0;
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ext_irq_enable_bit_r <= 1'b1;
            sm_r   <= 1'b0;
        end else if (in_rst) begin
            ext_irq_enable_bit_r <= 1'b1;
            sm_r   <= 1'b0;
        end else begin
            if (st_r == S_STOP) sm_r <= 1'b0;
            else if (wr_misc) sm_r <= WDATA[SM_B];
            // Changing the irq enable is only allowed while masked
            if (wr_misc && ibit_r) ext_irq_enable_bit_r <= WDATA[EXT_IRQ_ENABLE_BIT_B];
        end
    end

    // Latches: a new event wins over the service that clears it
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_r  <= 1'b0;
            wait_r <= 1'b0;
            stop_r <= 1'b0;
        end else if (in_rst) begin
            irq_r  <= 1'b0;
            wait_r <= 1'b0;
            stop_r <= 1'b0;
        end else begin
            if (IRQ_EVT) irq_r <= 1'b1;
            else if (take_r && vec_r == VEC_IRQ) irq_r <= 1'b0;
            if (WAIT_EXEC) wait_r <= 1'b1;
            else if (hw_any) wait_r <= 1'b0;
            stop_r <= (st_nxt == S_STOP) || (st_nxt == S_STUP);
        end
    end

    // Mask bit and vector selection
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ibit_r  <= 1'b1;
            take_r  <= 1'b0;
            fetch_r <= 1'b0;
            vec_r   <= VEC_RESET;
        end else begin
            take_r  <= 1'b0;
            fetch_r <= 1'b0;
            if (in_rst) begin
                ibit_r <= 1'b1;
                vec_r  <= VEC_RESET;
                fetch_r <= (st_nxt == S_RUN);
            end else if (st_r == S_RUN) begin
                if (SWI_EXEC) begin
                    ibit_r <= 1'b1;
                    take_r <= 1'b1;
                    vec_r  <= VEC_SWI;
                end else if (INSTR_DONE && !ibit_r && hw_any) begin
                    ibit_r <= 1'b1;
                    take_r <= 1'b1;
                    vec_r  <= pick_vec(req);
                end else if (RTI_EXEC) begin
                    ibit_r <= STACKED_I;
                end else if (WAIT_EXEC || STOP_EXEC) begin
                    ibit_r <= 1'b0;
                end
            end
        end
    end

    // Register read port
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= 8'h00;
        end else if (RD && ADDR == MISC_OFS) begin
            rdata_r <= 8'h00;
            rdata_r[POR_B]  <= por_r;
            rdata_r[EXT_IRQ_ENABLE_BIT_B] <= ext_irq_enable_bit_r;
            rdata_r[SM_B]   <= sm_r;
            rdata_r[WATCHDOG_ARM_BIT_B] <= watchdog_arm_bit_r;
        end else if (RD && ADDR == STAT_OFS) begin
            rdata_r <= 8'h00;
            rdata_r[ST_CNT_LSB +: DOG_W] <= dog_r;
            rdata_r[ST_WAIT_B] <= wait_r;
            rdata_r[ST_STOP_B] <= stop_r;
            rdata_r[ST_IBIT_B] <= ibit_r;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign RDATA        = rdata_r;
    assign RESET_PIN_O  = 1'b0;
    assign RESET_PIN_OE = (st_r == S_PWR) || (st_r == S_DOG);
    assign CHIP_RST     = in_rst;
    assign FETCH_RV     = fetch_r;
    assign INT_TAKE     = take_r;
    assign VEC_ADDR     = vec_r;
    assign I_BIT        = ibit_r;
    assign OSC_EN       = !(st_r == S_PWR || st_r == S_STOP || st_r == S_STUP);
    assign CLK_CLR      = !OSC_EN;
    assign ADC_EEP_RST  = in_rst || st_r == S_STOP || st_r == S_STUP;
    assign SM_BIT       = sm_r;
    assign EXT_IRQ_ENABLE_BIT_BIT     = ext_irq_enable_bit_r;
    assign TMR_LOAD     = TMR_INIT;
    assign SP_LOAD      = SP_INIT;
    assign IN_WAIT      = wait_r;
    assign IN_STOP      = stop_r;

    // Consecutive low pin cycles, counted apart from the sequencer's counter
    // so that the release check does not lean on the logic it guards
    logic [CNT_W-1:0]    low_run_r;

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r)
            low_run_r <= '0;
        else if (pin_r)
            low_run_r <= '0;
        else if (!(&low_run_r))
            low_run_r <= low_run_r + 1'b1;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!rst_n_r);

    sequence s_final;
        st_r == S_RUN && timeout && pin_r;
    endsequence

    a_timeout_reset: assert property (s_final |=> st_r == S_DOG)
        else $error("timeout did not start watchdog reset");
    a_zero_keeps: assert property (
        watchdog_arm_bit_r && !in_rst && st_r != S_STOP |=> watchdog_arm_bit_r)
        else $error("watchdog enable dropped");
    a_kick_clears: assert property (
        wr_misc && WDATA[WATCHDOG_ARM_BIT_B] |=> dog_r == 3'h0)
        else $error("counter not cleared by kick");
    a_stop_dog: assert property (
        st_r == S_RUN && pin_r && STOP_EXEC && watchdog_arm_bit_r |=> st_r == S_DOG)
        else $error("STOP with watchdog did not reset");
    a_pin_release: assert property (
        st_r == S_DOG |=> RESET_PIN_OE || low_run_r >= CNT_W'(DOGL_CYC))
        else $error("pin released early");
    a_reset_mask: assert property (in_rst |=> ibit_r)
        else $error("mask not set in reset");
    a_swi_vec: assert property (
        st_r == S_RUN && SWI_EXEC |=> take_r && vec_r == VEC_SWI)
        else $error("software trap vector wrong");
    a_irq_first: assert property (
        st_r == S_RUN && !SWI_EXEC && INSTR_DONE && !ibit_r && req[4]
        |=> vec_r == VEC_IRQ) else $error("priority wrong");
    a_por_sticky: assert property (!por_r |=> !por_r)
        else $error("power flag set by software");
    a_wait_hold: assert property (
        dog_hold && !in_rst |=> dog_r == 3'h0)
        else $error("counter ran in held WAIT");
endmodule

// *** bench/cwr_pin_model.sv ***
// Reset pin model: open drain wire with slow pull-up and external switch
`timescale 1ns/1ps
module cwr_pin_model #(
    parameter int RISE_DLY = 3
) (
    input  wire logic clk,     // Bus clock
    input  wire logic pin_oe,  // Device pulls the pin
    input  wire logic pin_o,   // Device drive value
    input  wire logic ext_low, // External reset switch closed
    output logic      pin_lvl  // Level seen on the wire
);
    int unsigned rise_cnt;
    wire logic   pulled = (pin_oe & ~pin_o) | ext_low;

    // RC pull-up: the wire climbs back slowly, never at once
    always_ff @(posedge clk or posedge pulled) begin
        if (pulled) begin
            rise_cnt <= 0;
        end else if (rise_cnt < RISE_DLY) begin
            rise_cnt <= rise_cnt + 1;
        end
    end

    assign pin_lvl = !pulled && rise_cnt >= RISE_DLY;
endmodule

// *** bench/test_cop_watchdog_reset_irq_ctrl.sv ***
// Self-checking bench for the watchdog, reset and interrupt controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
`define PULSE(s) begin @(posedge REF_CLK) s <= 1'b1; \
    @(posedge REF_CLK) s <= 1'b0; #1; end
`define WAITHI(s, lim, nm) begin wt = 0; while ((s) !== 1'b1) begin \
    @(negedge REF_CLK); wt++; \
    if (wt > (lim)) begin `CHK(nm, 1'b1, s) end_sim(); end end end
module test_cop_watchdog_reset_irq_ctrl;
    import cwr_pkg::*;
    localparam int PORL = 16;
    logic        REF_CLK, RST_N, WR, RD, RESET_PIN_I, TMR_CARRY, INSTR_DONE;
    logic        SWI_EXEC, RTI_EXEC, STACKED_I, STOP_EXEC, WAIT_EXEC;
    logic        IRQ_EVT, ext_low, RESET_PIN_O, RESET_PIN_OE, CHIP_RST;
    logic        FETCH_RV, INT_TAKE, I_BIT, OSC_EN, CLK_CLR, ADC_EEP_RST;
    logic        SM_BIT, EXT_IRQ_ENABLE_BIT_BIT, IN_WAIT, IN_STOP;
    logic [7:0]  ADDR, WDATA, RDATA, rv;
    logic [3:0]  HW_REQ, HW_EN;
    logic [15:0] VEC_ADDR, TMR_LOAD, SP_LOAD;
    int          err_count, num_checks, wt, i;

    cwr_ctrl #(.WATCHDOG_ARM_BIT_OPT(1'b0), .WAIT_RUN(1'b1), .PORL_CYC(PORL))
    cwr_ctrl_inst (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .RESET_PIN_I(RESET_PIN_I),
        .RESET_PIN_O(RESET_PIN_O), .RESET_PIN_OE(RESET_PIN_OE),
        .TMR_CARRY(TMR_CARRY), .INSTR_DONE(INSTR_DONE),
        .SWI_EXEC(SWI_EXEC), .RTI_EXEC(RTI_EXEC), .STACKED_I(STACKED_I),
        .STOP_EXEC(STOP_EXEC), .WAIT_EXEC(WAIT_EXEC), .IRQ_EVT(IRQ_EVT),
        .HW_REQ(HW_REQ), .HW_EN(HW_EN), .CHIP_RST(CHIP_RST),
        .FETCH_RV(FETCH_RV), .INT_TAKE(INT_TAKE), .VEC_ADDR(VEC_ADDR),
        .I_BIT(I_BIT), .OSC_EN(OSC_EN), .CLK_CLR(CLK_CLR),
        .ADC_EEP_RST(ADC_EEP_RST), .SM_BIT(SM_BIT), .EXT_IRQ_ENABLE_BIT_BIT(EXT_IRQ_ENABLE_BIT_BIT),
        .TMR_LOAD(TMR_LOAD), .SP_LOAD(SP_LOAD), .IN_WAIT(IN_WAIT),
        .IN_STOP(IN_STOP));

    cwr_pin_model #(.RISE_DLY(3)) cwr_pin_model_inst (
        .clk(REF_CLK), .pin_oe(RESET_PIN_OE), .pin_o(RESET_PIN_O),
        .ext_low(ext_low), .pin_lvl(RESET_PIN_I));

    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    task end_sim();
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK) ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK) WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge REF_CLK) ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK) RD <= 1'b0;
        #1;
        `CHK(nm, e, RDATA)
    endtask

    task return_from_trap_instr(input logic v);
        @(posedge REF_CLK) STACKED_I <= v;
        RTI_EXEC <= 1'b1;
        @(posedge REF_CLK) RTI_EXEC <= 1'b0;
        #1;
    endtask

    task carries(input int n);
        repeat (n) begin
            @(posedge REF_CLK) TMR_CARRY <= 1'b1;
            @(posedge REF_CLK) TMR_CARRY <= 1'b0;
        end
        #1;
    endtask

    task t_reset();
        repeat (4) @(negedge REF_CLK);
        `CHK("pin_oe", 1'b1, RESET_PIN_OE)
        `CHK("osc_en", 1'b0, OSC_EN)
        `CHK("clk_clr", 1'b1, CLK_CLR)
        `WAITHI(FETCH_RV, 200, "fetch")
        `CHK("vec", VEC_RESET, VEC_ADDR)
        `CHK("chip_rst", 1'b0, CHIP_RST)
        `CHK("tmr", 16'hfffc, TMR_LOAD)
        `CHK("sp", 16'h00ff, SP_LOAD)
        `CHK("latches", 2'b00, {IN_WAIT, IN_STOP})
        rchk(MISC_OFS, 8'h90, "misc");
        rchk(STAT_OFS, 8'h20, "stat");
    endtask

    task t_bus();
        wr(MISC_OFS, 8'h10);
        rchk(MISC_OFS, 8'h10, "misc");
        wr(MISC_OFS, 8'h92);
        rchk(MISC_OFS, 8'h12, "misc");
        rchk(8'h3f, 8'h00, "unmapped");
        `CHK("sm", 1'b1, SM_BIT)
    endtask

    task t_irq();
        logic [15:0] vec [4];
        vec = '{VEC_CAP, VEC_CMP, VEC_OVF, VEC_SCI};
        @(posedge REF_CLK) HW_REQ <= 4'hf;
        HW_EN <= 4'hf;
        `PULSE(INSTR_DONE)
        `CHK("take", 1'b0, INT_TAKE)
        for (int k = 0; k < 4; k++) begin
            return_from_trap_instr(1'b0);
            `CHK("ibit", 1'b0, I_BIT)
            @(posedge REF_CLK) HW_REQ <= 4'hf >> k;
            `PULSE(INSTR_DONE)
            `CHK("take", 1'b1, INT_TAKE)
            `CHK("vec", vec[k], VEC_ADDR)
            `CHK("ibit", 1'b1, I_BIT)
        end
        repeat (2) @(negedge REF_CLK);
        `CHK("take", 1'b0, INT_TAKE)
        return_from_trap_instr(1'b0);
        @(posedge REF_CLK) HW_EN <= 4'h0;
        `PULSE(INSTR_DONE)
        `CHK("take", 1'b0, INT_TAKE)
        @(posedge REF_CLK) HW_EN <= 4'hf;
        HW_REQ <= 4'h8;
        `PULSE(IRQ_EVT)
        `PULSE(INSTR_DONE)
        `CHK("vec", VEC_IRQ, VEC_ADDR)
        return_from_trap_instr(1'b0);
        `PULSE(INSTR_DONE)
        `CHK("vec", VEC_CAP, VEC_ADDR)
        return_from_trap_instr(1'b1);
        `CHK("ibit", 1'b1, I_BIT)
    endtask

    task t_swi();
        `PULSE(SWI_EXEC)
        `CHK("take", 1'b1, INT_TAKE)
        `CHK("vec", VEC_SWI, VEC_ADDR)
        return_from_trap_instr(1'b0);
        @(posedge REF_CLK) SWI_EXEC <= 1'b1;
        INSTR_DONE <= 1'b1;
        @(posedge REF_CLK) SWI_EXEC <= 1'b0;
        INSTR_DONE <= 1'b0;
        #1;
        `CHK("vec", VEC_SWI, VEC_ADDR)
        return_from_trap_instr(1'b0);
        `PULSE(INSTR_DONE)
        `CHK("vec", VEC_CAP, VEC_ADDR)
        @(posedge REF_CLK) HW_REQ <= 4'h0;
    endtask

    task t_wait();
        `PULSE(WAIT_EXEC)
        `CHK("wait", 1'b1, IN_WAIT)
        `CHK("ibit", 1'b0, I_BIT)
        // Irq enable must refuse a change while unmasked
        wr(MISC_OFS, 8'h02);
        rchk(MISC_OFS, 8'h12, "misc");
        rchk(STAT_OFS, 8'h08, "stat");
        @(posedge REF_CLK) HW_REQ <= 4'h4;
        `WAITHI(!IN_WAIT, 20, "wait_exit")
        @(posedge REF_CLK) HW_REQ <= 4'h0;
    endtask

    task t_stop();
        `PULSE(STOP_EXEC)
        repeat (2) @(negedge REF_CLK);
        `CHK("osc_en", 1'b0, OSC_EN)
        `CHK("clk_clr", 1'b1, CLK_CLR)
        `CHK("stop", 1'b1, IN_STOP)
        `CHK("sm", 1'b0, SM_BIT)
        `CHK("adc_eep", 1'b1, ADC_EEP_RST)
        `CHK("ibit", 1'b0, I_BIT)
        `PULSE(IRQ_EVT)
        for (i = 0; i < OSC_HOLD_CYC + 20 && OSC_EN !== 1'b1; i++)
            @(negedge REF_CLK);
        wt = i - OSC_HOLD_CYC;
        `CHK("hold", 1'b1, wt >= -4 && wt <= 8)
        `PULSE(INSTR_DONE)
        `CHK("vec", VEC_IRQ, VEC_ADDR)
    endtask

    task watchdog_timeout_time();
        wr(MISC_OFS, 8'h11);
        rchk(MISC_OFS, 8'h11, "misc");
        wr(MISC_OFS, 8'h10);
        rchk(MISC_OFS, 8'h11, "misc");
        carries(6144);
        `CHK("pin_oe", 1'b0, RESET_PIN_OE)
        wr(MISC_OFS, 8'h11);
        carries(6144);
        `CHK("pin_oe", 1'b0, RESET_PIN_OE)
        for (i = 0; i < 1100 && RESET_PIN_OE !== 1'b1; i++)
            carries(1);
        `CHK("dog_time", 1'b1, i > 0 && i <= 1025)
        `CHK("chip_rst", 1'b1, CHIP_RST)
        `CHK("pin_o", 1'b0, RESET_PIN_O)
        for (i = 0; i < 200 && RESET_PIN_OE === 1'b1; i++)
            @(negedge REF_CLK);
        `CHK("dogl", 1'b1, i >= DOGL_CYC && i <= DOGL_CYC + 6)
        `WAITHI(FETCH_RV, 100, "fetch")
        `CHK("vec", VEC_RESET, VEC_ADDR)
        rchk(MISC_OFS, 8'h10, "misc");
    endtask

    task t_stopdog();
        wr(MISC_OFS, 8'h11);
        `PULSE(STOP_EXEC)
        `WAITHI(RESET_PIN_OE, 10, "pin_oe")
        `CHK("osc_en", 1'b1, OSC_EN)
        `WAITHI(FETCH_RV, 300, "fetch")
        rchk(MISC_OFS, 8'h10, "misc");
    endtask

    task t_ext();
        wr(MISC_OFS, 8'h02);
        @(negedge REF_CLK);
        `CHK("ext_irq_enable_bit", 1'b0, EXT_IRQ_ENABLE_BIT_BIT)
        @(posedge REF_CLK) ext_low <= 1'b1;
        repeat (5) @(negedge REF_CLK);
        `CHK("chip_rst", 1'b1, CHIP_RST)
        `CHK("osc_en", 1'b1, OSC_EN)
        @(posedge REF_CLK) ext_low <= 1'b0;
        `WAITHI(FETCH_RV, 100, "fetch")
        `CHK("ibit", 1'b1, I_BIT)
        rchk(MISC_OFS, 8'h10, "misc");
        `CHK("ext_irq_enable_bit", 1'b1, EXT_IRQ_ENABLE_BIT_BIT)
    endtask

    initial begin
        {RST_N, WR, RD, TMR_CARRY, INSTR_DONE, SWI_EXEC, RTI_EXEC} = '0;
        {STACKED_I, STOP_EXEC, WAIT_EXEC, IRQ_EVT, ext_low} = '0;
        {ADDR, WDATA, HW_REQ, HW_EN} = '0;
        err_count = 0;
        num_checks = 0;
        repeat (3) @(posedge REF_CLK);
        RST_N <= 1'b1;
        t_reset();
        t_bus();
        t_irq();
        t_swi();
        t_wait();
        t_stop();
        watchdog_timeout_time();
        t_stopdog();
        t_ext();
        end_sim();
    end
endmodule
